// file: dts_pkg.sv
// constants shared by the transmit serializer, its host model and its bench
// assumes a 40 MHz device clock and byte-wide register access
package dts_pkg;
	localparam int BYTE_W = 8;
	localparam int CODE_W = 64;
	localparam int HALF_W = 32;
	localparam logic [7:0] ADDR_TX_STAT = 8'h0E;
	localparam logic [7:0] ADDR_TX_DATA = 8'h0F;
	localparam logic [7:0] ADDR_TX_QUAL = 8'h10;
	localparam logic [7:0] ADDR_CODE_LO = 8'h11;
	localparam logic [7:0] ADDR_CODE_HI = 8'h18;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] QUAL_RESET = 8'h00;
	localparam logic [63:0] CODE_RESET = 64'h1E8B6A3DE0E9B222;
	localparam int ST_EMPTY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_OVF = 2;
	localparam int ST_UNF = 3;
	localparam int CLK_PERIOD_NS = 25;
	// chip period, one chip per microsecond by default
	localparam int CHIP_TIME_NS = 1000;
	localparam int CHIP_CYCLES = (CHIP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FIFO_DEPTH = 16;
	localparam logic PREAMBLE_BIT = 1'b1;
	typedef enum logic [1:0] {MODE_FULL, MODE_LOW, MODE_HIGH, MODE_BOTH} dts_mode_t;
	typedef enum logic {ST_IDLE, ST_SEND} dts_state_t;
endpackage : dts_pkg

// file: dts_fifo.sv
// synchronous fifo, flip-flop storage, valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module dts_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign inReady = count_r != (AW+1)'(DEPTH);
	assign outValid = count_r != '0;
	assign outData = mem_r[rdPtr_r];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wrPtr_r] <= inData;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule : dts_fifo

// file: dts_tx_serializer.sv
// transmit serializer and chip spreader for a dsss radio
// assumes a register port driven on clk by the host-interface logic
// What this block does
// - data byte goes out bit zero first, bit seven last.
// - each qualifier bit marks its matching data bit valid or invalid.
// - valid bit sends data, invalid bit sends preamble in that bit time.
// - shifting continues while any qualifier bit remains, then stops.
// - qualifier of low four bits sends only the low nibble.
// - 64-bit code register spreads every bit in 64-chip mode.
// - code also usable as two 32-chip halves, alone or alternating.
// - code chips go out from bit zero to bit sixty-three.
// - code held as eight bytes, lowest address holds bits seven to zero.
// - empty set when byte enters transmitter, cleared by data write.
// - underflow flagged when next data is missing after bits were sent.
// - overflow flagged on data write while the byte queue is full; status read clears.
// - done flagged when a byte finishes with nothing pending.
`timescale 1ns/1ps
module dts_tx_serializer
#(
	parameter int CHIPS_PER_TICK = dts_pkg::CHIP_CYCLES,
	parameter int DEPTH = dts_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	output logic dataReady,
	input wire dts_pkg::dts_mode_t codeMode,
	output logic chipOut,
	output logic chipStrobe,
	output logic txBusy
);
	import dts_pkg::*;

	localparam int DW = $clog2(CHIPS_PER_TICK + 1);

	logic [7:0] txData_r;
	logic [7:0] txQual_r;
	logic [63:0] code_r;
	logic [3:0] stat_r;
	logic [7:0] regRdData_r;
	dts_state_t state_r;
	logic [7:0] shData_r;
	logic [7:0] shQual_r;
	logic [5:0] chipIdx_r;
	logic [DW-1:0] div_r;
	logic half_r;
	logic chipOut_r;
	logic chipStrobe_r;

	logic dataWr;
	logic statRd;
	logic fifoInReady;
	logic fifoOutValid;
	logic [15:0] fifoOut;
	logic loadNow;
	logic chipTick;
	logic bitEnd;
	logic byteEnd;
	logic curBit;
	logic [5:0] codeIdx;
	logic [6:0] bitLen;

	assign dataWr = regWr && (regAddr == ADDR_TX_DATA);
	assign statRd = regRd && (regAddr == ADDR_TX_STAT);
	assign dataReady = fifoInReady;
	assign regRdData = regRdData_r;
	assign chipOut = chipOut_r;
	assign chipStrobe = chipStrobe_r;
	assign txBusy = state_r == ST_SEND;

	////////////////////////////////////////////////////////////////////////////////
	// register writes

	always_ff @(posedge clk) begin
		if (rst) begin
			txData_r <= DATA_RESET;
			txQual_r <= QUAL_RESET;
		end else if (regWr && regAddr == ADDR_TX_DATA) begin
			txData_r <= regWrData;
		end else if (regWr && regAddr == ADDR_TX_QUAL) begin
			txQual_r <= regWrData;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			code_r <= CODE_RESET;
		end else begin
			for (int i = 0; i < CODE_W / BYTE_W; i++) begin
				if (regWr && regAddr == ADDR_CODE_LO + 8'(i)) begin
					code_r[BYTE_W*i +: BYTE_W] <= regWrData;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// byte queue: each entry carries the qualifier in force at the data write

	dts_fifo #(
		.WIDTH(2 * BYTE_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.inValid(dataWr),
		.inReady(fifoInReady),
		.inData({txQual_r, regWrData}),
		.outValid(fifoOutValid),
		.outReady(loadNow),
		.outData(fifoOut)
	);

	////////////////////////////////////////////////////////////////////////////////
	// bit and chip engine

	assign bitLen = (codeMode == MODE_FULL) ? 7'(CODE_W) : 7'(HALF_W);
	assign codeIdx = (codeMode == MODE_HIGH || (codeMode == MODE_BOTH && half_r)) ?
		6'(HALF_W) + chipIdx_r : chipIdx_r;
	assign chipTick = div_r == DW'(CHIPS_PER_TICK - 1);
	assign bitEnd = (state_r == ST_SEND) && chipTick && (chipIdx_r == 6'(bitLen - 7'd1));
	// stop when no qualifier bit is left
	assign byteEnd = bitEnd && (shQual_r[7:1] == '0);
	assign loadNow = fifoOutValid && ((state_r == ST_IDLE) || byteEnd);
	assign curBit = shQual_r[0] ? shData_r[0] : PREAMBLE_BIT;

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			shData_r <= '0;
			shQual_r <= '0;
		end else if (loadNow) begin
			shData_r <= fifoOut[7:0];
			shQual_r <= fifoOut[15:8];
			// a byte with no qualified bits is consumed without air time
			state_r <= (fifoOut[15:8] != '0) ? ST_SEND : ST_IDLE;
		end else if (bitEnd) begin
			// nibble stop falls out of the shift
			shData_r <= shData_r >> 1;
			shQual_r <= shQual_r >> 1;
			if (byteEnd) begin
				state_r <= ST_IDLE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst || state_r == ST_IDLE) begin
			div_r <= '0;
			chipIdx_r <= '0;
		end else if (chipTick) begin
			div_r <= '0;
			chipIdx_r <= bitEnd ? '0 : chipIdx_r + 1'b1;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || state_r == ST_IDLE) begin
			half_r <= 1'b0;
		end else if (bitEnd && codeMode == MODE_BOTH) begin
			half_r <= ~half_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			chipOut_r <= 1'b0;
			chipStrobe_r <= 1'b0;
		end else begin
			chipStrobe_r <= (state_r == ST_SEND) && chipTick;
			if ((state_r == ST_SEND) && chipTick) begin
				chipOut_r <= code_r[codeIdx] ^ ~curBit;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status flags: a set in the same cycle as a clear wins

	always_ff @(posedge clk) begin
		if (rst) begin
			stat_r <= '0;
		end else begin
			if (loadNow) begin
				stat_r[ST_EMPTY] <= 1'b1;
			end else if (dataWr) begin
				stat_r[ST_EMPTY] <= 1'b0;
			end
			if (byteEnd && !fifoOutValid) begin
				stat_r[ST_DONE] <= 1'b1;
			end else if (statRd) begin
				stat_r[ST_DONE] <= 1'b0;
			end
			if (dataWr && !fifoInReady) begin
				stat_r[ST_OVF] <= 1'b1;
			end else if (statRd) begin
				stat_r[ST_OVF] <= 1'b0;
			end
			if (byteEnd && !fifoOutValid) begin
				stat_r[ST_UNF] <= 1'b1;
			end else if (statRd) begin
				stat_r[ST_UNF] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register reads, answered one cycle after the strobe

	always_ff @(posedge clk) begin
		if (rst) begin
			regRdData_r <= '0;
		end else if (regRd) begin
			if (regAddr == ADDR_TX_STAT) begin
				regRdData_r <= {4'h0, stat_r};
			end else if (regAddr == ADDR_TX_DATA) begin
				regRdData_r <= txData_r;
			end else if (regAddr == ADDR_TX_QUAL) begin
				regRdData_r <= txQual_r;
			end else if (regAddr >= ADDR_CODE_LO && regAddr <= ADDR_CODE_HI) begin
				regRdData_r <= code_r[BYTE_W * 3'(regAddr - ADDR_CODE_LO) +: BYTE_W];
			end else begin
				regRdData_r <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	a_empty_set: assert property (@(posedge clk) disable iff (rst)
		loadNow |=> stat_r[ST_EMPTY]) else $error("empty not set on load");
	a_empty_clear: assert property (@(posedge clk) disable iff (rst)
		dataWr && !loadNow |=> !stat_r[ST_EMPTY]) else $error("data write did not clear empty");
	a_ovf_set: assert property (@(posedge clk) disable iff (rst)
		dataWr && !fifoInReady |=> stat_r[ST_OVF]) else $error("overflow missed");
	a_ovf_clear: assert property (@(posedge clk) disable iff (rst)
		statRd && !(dataWr && !fifoInReady) |=> !stat_r[ST_OVF]) else $error("status read left overflow");
	a_done_flags: assert property (@(posedge clk) disable iff (rst)
		byteEnd && !fifoOutValid |=> stat_r[ST_DONE] && stat_r[ST_UNF] && state_r == ST_IDLE)
		else $error("done or underflow missed at byte end");
	a_shift_lsb: assert property (@(posedge clk) disable iff (rst)
		bitEnd && !byteEnd |=> shData_r == ($past(shData_r) >> 1)) else $error("shift order wrong");
	a_send_valid: assert property (@(posedge clk) disable iff (rst)
		state_r == ST_SEND |-> shQual_r != '0) else $error("sending with no qualified bits");
	a_chip_value: assert property (@(posedge clk) disable iff (rst)
		(state_r == ST_SEND) && chipTick |=> chipStrobe_r &&
		chipOut_r == ($past(code_r[codeIdx]) ^ ~$past(curBit))) else $error("chip polarity wrong");
	a_bit_length: assert property (@(posedge clk) disable iff (rst)
		bitEnd && codeMode == MODE_FULL |-> chipIdx_r == 6'(CODE_W - 1)) else $error("full bit not 64 chips");
	a_code_byte0: assert property (@(posedge clk) disable iff (rst)
		regWr && regAddr == ADDR_CODE_LO |=> code_r[7:0] == $past(regWrData)) else $error("code byte 0 not written");
endmodule : dts_tx_serializer

// file: dts_host_model.sv
// host side of the register port: byte writes and reads
// assumes the bench calls the tasks just after a clk edge
`timescale 1ns/1ps
module dts_host_model
	import dts_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] regRdData,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWr,
	output logic regRd
);
	initial begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// strobe left high so back-to-back writes never double-assign it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		regRd <= 1'b0;
	endtask : wr
	task automatic idle();
		@(posedge clk);
		regWr <= 1'b0;
		regRd <= 1'b0;
	endtask : idle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWr <= 1'b0;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
		#1;
		d = regRdData;
	endtask : rd
	// known code only
	// only the reset code is spread, so correlation stays sound
	// paced data write
	// one byte, qualifier first, then the write strobe dropped; does not wait for an idle transmitter
	task automatic put(input logic [7:0] q, input logic [7:0] d);
		wr(ADDR_TX_QUAL, q);
		wr(ADDR_TX_DATA, d);
		idle();
	endtask : put
endmodule : dts_host_model

// file: tb_top.sv
// self-checking bench for the transmit serializer
// assumes the host model drives every register access
`timescale 1ns/1ps
module tb_top;
	import dts_pkg::*;
	localparam int CPT = 2;
	typedef struct {logic [7:0] qual; logic [7:0] data; dts_mode_t mode; int chips;} dts_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	dts_mode_t codeMode = MODE_FULL;
	logic [7:0] regAddr, regWrData, regRdData, rdv;
	logic regWr, regRd, dataReady, chipOut, chipStrobe, txBusy, c;
	int n_errors = 0;
	int checked = 0;
	int cycles = 0;
	int k, n;
	logic q[$];
	dts_row_t rows[4];
	always #12.5 clk = ~clk;
	dts_tx_serializer #(.CHIPS_PER_TICK(CPT), .DEPTH(4)) dut (.clk(clk), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .dataReady(dataReady),
		.codeMode(codeMode), .chipOut(chipOut), .chipStrobe(chipStrobe), .txBusy(txBusy));
	dts_host_model host (.clk(clk), .regRdData(regRdData), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd));
	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles++;
		if (chipStrobe === 1'b1) q.push_back(chipOut);
		if (cycles == 30000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////
	initial begin
		rows = '{'{8'hFF, 8'hA5, MODE_FULL, 512}, '{8'h0F, 8'h3C, MODE_LOW, 128}, '{8'h05, 8'h02, MODE_HIGH, 96},
			'{8'h0B, 8'h01, MODE_BOTH, 128}};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		host.wr(ADDR_TX_STAT, 8'hFF);
		host.rd(ADDR_TX_STAT, rdv);
		chk(rdv, 8'h00);
		host.rd(ADDR_TX_DATA, rdv);
		chk(rdv, DATA_RESET);
		host.rd(ADDR_TX_QUAL, rdv);
		chk(rdv, QUAL_RESET);
		for (int i = 0; i < 8; i++) begin
			host.rd(ADDR_CODE_LO + 8'(i), rdv);
			chk(rdv, CODE_RESET[i*8 +: 8]);
		end
		host.wr(ADDR_CODE_LO, 8'h5A);
		host.rd(ADDR_CODE_LO, rdv);
		chk(rdv, 8'h5A);
		host.wr(ADDR_CODE_LO, CODE_RESET[7:0]);
		host.rd(8'h20, rdv);
		chk(rdv, 8'h00);
		foreach (rows[r]) begin
			@(posedge clk);
			codeMode <= rows[r].mode;
			q.delete();
			host.put(rows[r].qual, rows[r].data);
			for (n = 0; n < 3000 && !(n > 5 && txBusy === 1'b0); n++) @(posedge clk);
			chk(txBusy, 1'b0);
			repeat (4) @(posedge clk);
			k = 0;
			for (int i = 0; i < 8 && (rows[r].qual >> i) != 0; i++) begin
				for (int j = 0; j < (rows[r].mode == MODE_FULL ? 64 : 32); j++) begin
					c = CODE_RESET[j + (rows[r].mode == MODE_HIGH || (rows[r].mode == MODE_BOTH && i % 2 == 1) ? 32 : 0)];
					c = c ^ ~(rows[r].qual[i] ? rows[r].data[i] : PREAMBLE_BIT);
					if (k < q.size()) chk(q[k], c);
					k++;
				end
			end
			chk(16'(q.size()), 16'(k));
			chk(16'(q.size()), 16'(rows[r].chips));
		end
		host.rd(ADDR_TX_STAT, rdv);
		chk(rdv, 8'h0B);
		host.rd(ADDR_TX_STAT, rdv);
		chk(rdv, 8'h01);
		for (int i = 0; i < 7; i++) host.wr(ADDR_TX_DATA, 8'(i));
		host.idle();
		#1;
		chk(dataReady, 1'b0);
		host.rd(ADDR_TX_STAT, rdv);
		chk(rdv & 8'h04, 8'h04);
		host.rd(ADDR_TX_STAT, rdv);
		chk(rdv & 8'h04, 8'h00);
		// reset while bytes are still on the air
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk(txBusy, 1'b0);
		chk(chipStrobe, 1'b0);
		chk(dataReady, 1'b1);
		host.rd(ADDR_TX_STAT, rdv);
		chk(rdv, 8'h00);
		host.rd(ADDR_CODE_HI, rdv);
		chk(rdv, CODE_RESET[63:56]);
		close_out();
	end
endmodule : tb_top
